// >>> hdl/irq_pkg.sv
// constants, types and map shared by both ends of the interrupt link
package irq_pkg;

  // ==========================================================
  // device map
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 8;
  localparam logic [15:0] VECTOR_ADDR    = 16'h0000;
  localparam logic [15:0] SP_LO_ADDR     = 16'h0002;
  localparam logic [15:0] SP_HI_ADDR     = 16'h0003;
  localparam logic [15:0] CTRL_BASE_ADDR = 16'h0055;
  localparam logic [15:0] DUMMY_ADDR     = 16'h0002;
  localparam logic [15:0] SP_RESET       = 16'h0000;

  // ==========================================================
  // interrupt control register fields
  localparam int         LEVEL_LSB      = 0;
  localparam int         LEVEL_W        = 3;
  localparam int         REQ_BIT        = 3;
  localparam int         POL_BIT        = 4;
  localparam logic [7:0] CTL_USED_MASK  = 8'h1f;
  localparam logic [7:0] CTL_RESET      = 8'h00;
  localparam logic [7:0] REQ_CLEAR_MASK = 8'hf7;
  localparam int         NUM_W          = 5;

  // ==========================================================
  // cpu sequencer registers on the software port
  localparam logic [3:0] H_CTRL      = 4'h0;
  localparam logic [3:0] H_STATUS    = 4'h1;
  localparam logic [3:0] H_MASK      = 4'h2;
  localparam logic [3:0] H_VECTOR    = 4'h3;
  localparam logic [3:0] H_PASS_ADDR = 4'h4;
  localparam logic [3:0] H_PASS_DATA = 4'h5;
  localparam logic [3:0] H_PASS_READ = 4'h6;
  localparam logic [3:0] H_CLEAR_REQ = 4'h7;
  localparam logic [3:0] H_SP_STATE  = 4'h8;

  localparam int         I_BIT       = 0;
  localparam int         HOLD_BIT    = 1;
  localparam int         IPL_LSB     = 4;
  localparam int         ST_TAKEN    = 0;
  localparam int         ST_CLEARED  = 1;
  localparam int         ST_REFUSED  = 2;
  localparam int         ST_W        = 3;
  localparam logic [2:0] STATUS_RESET = 3'h0;

  // ==========================================================
  // timing: instruction slots before an enable takes effect
  localparam int NOP_COUNT      = 2;
  localparam int NOP_COUNT_HOLD = 4;
  localparam int WAIT_W         = 3;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ACK     = 3'b001,
    ST_PASS_RD = 3'b010,
    ST_CLR_RD  = 3'b011,
    ST_CLR_WR  = 3'b100,
    ST_DUMMY   = 3'b101
  } seq_state_t;

endpackage

// >>> hdl/irq_link_if.sv
// interface joining the cpu sequencer and the request controller
`timescale 1ns/1ns
interface irq_link_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq_req;
  logic [2:0]  irq_level;

  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output irq_req,
    output irq_level
  );

  modport cpu (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  irq_req,
    input  irq_level
  );
endinterface // irq_link_if

// >>> hdl/irq_request_ctl.sv
// interrupt request controller: control registers, vector read, stack ptr
`timescale 1ns/1ns
module irq_request_ctl #(
  parameter int NUM_SRC = 4,
  parameter int NUM_EXT = 1
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // cpu side
  irq_link_if.dev                 link,
  // request sources
  input  wire logic [NUM_SRC-1:0] src_event,
  input  wire logic [NUM_EXT-1:0] ext_pin,
  // core state
  output logic      [15:0]        stack_ptr
);

  generate
    if (NUM_SRC < 1 || NUM_SRC > 32 || NUM_EXT < 1 || NUM_EXT > NUM_SRC)
      begin : g_bad
        $error("irq_request_ctl: unsupported source counts");
      end
  endgenerate

  localparam int EXT_BASE = NUM_SRC - NUM_EXT;

  logic [NUM_SRC-1:0][7:0] ctl;
  logic [NUM_SRC-1:0][7:0] next_ctl;
  logic [NUM_EXT-1:0]      act_prev;
  logic [NUM_EXT-1:0]      next_act_prev;
  logic [7:0]              rdata;
  logic [7:0]              next_rdata;
  logic                    irq_req;
  logic [2:0]              irq_level;
  logic [15:0]             next_stack_ptr;
  logic [NUM_SRC-1:0]      evt;
  logic [8:0]              win;
  logic [8:0]              next_win;

  // ==========================================================
  // highest enabled request: {found, level, number}
  function automatic logic [8:0] pick(
    input logic [NUM_SRC-1:0][7:0] c
  );
    logic [8:0] best;
    logic [2:0] lvl;
    best = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl = c[i][irq_pkg::LEVEL_LSB +: irq_pkg::LEVEL_W];
      if (c[i][irq_pkg::REQ_BIT] && lvl != 3'h0 &&
          (!best[8] || lvl > best[7:5])) begin
        best = {1'b1, lvl, 5'(i)};
      end
    end
    return best;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic act_now;
    act_now        = 1'b0;
    next_ctl       = ctl;
    next_act_prev  = act_prev;
    next_rdata     = 8'h00;
    next_stack_ptr = stack_ptr;
    win            = pick(ctl);
    evt            = src_event;
    // external inputs: edge on the active level; a polarity flip
    // moves the active level and can itself raise a request
    for (int j = 0; j < NUM_EXT; j++) begin
      act_now = ctl[EXT_BASE + j][irq_pkg::POL_BIT] ? ext_pin[j]
                                                    : ~ext_pin[j];
      evt[EXT_BASE + j] = act_now & ~act_prev[j];
      next_act_prev[j]  = act_now;
    end
    if (link.wr) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (link.addr == irq_pkg::CTRL_BASE_ADDR + 16'(i)) begin
          next_ctl[i] = link.wdata & irq_pkg::CTL_USED_MASK;
        end
      end
      if (link.addr == irq_pkg::SP_LO_ADDR) begin
        next_stack_ptr[7:0] = link.wdata;
      end
      if (link.addr == irq_pkg::SP_HI_ADDR) begin
        next_stack_ptr[15:8] = link.wdata;
      end
    end
    if (link.rd) begin
      if (link.addr == irq_pkg::VECTOR_ADDR) begin
        // any read here hands out and retires the top request
        if (win[8]) begin
          next_rdata = win[7:0];
          next_ctl[win[4:0]][irq_pkg::REQ_BIT] = 1'b0;
        end
      end
      for (int i = 0; i < NUM_SRC; i++) begin
        if (link.addr == irq_pkg::CTRL_BASE_ADDR + 16'(i)) begin
          next_rdata = ctl[i];
        end
      end
      if (link.addr == irq_pkg::SP_LO_ADDR) begin
        next_rdata = stack_ptr[7:0];
      end
      if (link.addr == irq_pkg::SP_HI_ADDR) begin
        next_rdata = stack_ptr[15:8];
      end
    end
    // a new request beats a clear or rewrite in the same cycle
    for (int i = 0; i < NUM_SRC; i++) begin
      if (evt[i]) begin
        next_ctl[i][irq_pkg::REQ_BIT] = 1'b1;
      end
    end
    next_win = pick(next_ctl);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl       <= {NUM_SRC{irq_pkg::CTL_RESET}};
      act_prev  <= '0;
      rdata     <= 8'h00;
      irq_req   <= 1'b0;
      irq_level <= 3'h0;
      stack_ptr <= irq_pkg::SP_RESET;
    end else begin
      ctl       <= next_ctl;
      act_prev  <= next_act_prev;
      rdata     <= next_rdata;
      irq_req   <= next_win[8];
      irq_level <= next_win[7:5];
      stack_ptr <= next_stack_ptr;
    end
  end

  assign link.rdata       = rdata;
  assign link.irq_req     = irq_req;
  assign link.irq_level   = irq_level;

endmodule // irq_request_ctl

// >>> hdl/cpu_irq_seq.sv
// cpu side: interrupt acceptance sequence and software command port
`timescale 1ns/1ns
module cpu_irq_seq #(
  parameter int NOP_COUNT      = irq_pkg::NOP_COUNT,
  parameter int NOP_COUNT_HOLD = irq_pkg::NOP_COUNT_HOLD
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // link to the request controller
  irq_link_if.cpu          link,
  // software register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // interrupt to software
  output logic             irq
);

  generate
    if (NOP_COUNT < 1 || NOP_COUNT_HOLD < NOP_COUNT ||
        NOP_COUNT_HOLD >= (1 << irq_pkg::WAIT_W)) begin : g_bad
      $error("cpu_irq_seq: unsupported enable delay");
    end
  endgenerate

  localparam logic [2:0] WAIT_N = 3'(NOP_COUNT);
  localparam logic [2:0] WAIT_H = 3'(NOP_COUNT_HOLD);

  irq_pkg::seq_state_t state;
  irq_pkg::seq_state_t next_state;

  logic        i_flag;
  logic        next_i_flag;
  logic        hold_mode;
  logic        next_hold_mode;
  logic [2:0]  ipl;
  logic [2:0]  next_ipl;
  logic [2:0]  en_wait;
  logic [2:0]  next_en_wait;
  logic        sp_loaded;
  logic        next_sp_loaded;
  logic [2:0]  status;
  logic [2:0]  next_status;
  logic [2:0]  mask;
  logic [2:0]  next_mask;
  logic [7:0]  vector;
  logic [7:0]  next_vector;
  logic [15:0] pass_addr;
  logic [15:0] next_pass_addr;
  logic [7:0]  pass_data;
  logic [7:0]  next_pass_data;
  logic [15:0] bus_addr;
  logic [15:0] next_bus_addr;
  logic [7:0]  bus_wdata;
  logic [7:0]  next_bus_wdata;
  logic        bus_wr;
  logic        next_bus_wr;
  logic        bus_rd;
  logic        next_bus_rd;
  logic        rd_valid;
  logic [15:0] next_reg_rdata;
  logic        next_irq;
  logic [2:0]  set_st;
  logic [2:0]  clr_st;
  logic        enabled;
  logic        accept;

  // ==========================================================
  // slots to wait after a device write or an enable
  function automatic logic [2:0] wait_len(input logic hold);
    return hold ? WAIT_H : WAIT_N;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_state     = state;
    next_i_flag    = i_flag;
    next_hold_mode = hold_mode;
    next_ipl       = ipl;
    next_en_wait   = (en_wait != 3'h0) ? en_wait - 3'h1 : 3'h0;
    next_sp_loaded = sp_loaded;
    next_mask      = mask;
    next_vector    = vector;
    next_pass_addr = pass_addr;
    next_pass_data = pass_data;
    next_bus_addr  = bus_addr;
    next_bus_wdata = bus_wdata;
    next_bus_wr    = 1'b0;
    next_bus_rd    = 1'b0;
    next_reg_rdata = 16'h0000;
    set_st         = 3'h0;
    clr_st         = 3'h0;

    // no acceptance until the enable has settled behind prior
    // writes and the stack pointer holds a real value
    enabled = i_flag && (en_wait == 3'h0) && sp_loaded;
    accept  = enabled && link.irq_req && (link.irq_level > ipl);

    // ---------------------------------------------- plain registers
    if (reg_wr) begin
      case (reg_addr)
        irq_pkg::H_CTRL: begin
          next_i_flag    = reg_wdata[irq_pkg::I_BIT];
          next_hold_mode = reg_wdata[irq_pkg::HOLD_BIT];
          next_ipl       = reg_wdata[irq_pkg::IPL_LSB +: 3];
          if (reg_wdata[irq_pkg::I_BIT] && !i_flag) begin
            next_en_wait = wait_len(reg_wdata[irq_pkg::HOLD_BIT]);
          end
        end
        irq_pkg::H_STATUS:    clr_st         = reg_wdata[2:0];
        irq_pkg::H_MASK:      next_mask      = reg_wdata[2:0];
        irq_pkg::H_PASS_ADDR: next_pass_addr = reg_wdata;
        default: ;
      endcase
    end

    // ---------------------------------------------- sequencer
    case (state)
      irq_pkg::ST_IDLE: begin
        if (reg_wr && reg_addr == irq_pkg::H_PASS_DATA) begin
          // one plain write of the whole byte
          next_bus_addr  = pass_addr;
          next_bus_wdata = reg_wdata[7:0];
          next_bus_wr    = 1'b1;
          next_pass_data = reg_wdata[7:0];
          next_en_wait   = wait_len(hold_mode);
          if (pass_addr == irq_pkg::SP_HI_ADDR) begin
            next_sp_loaded = 1'b1;
          end
        end else if (reg_wr && (reg_addr == irq_pkg::H_PASS_READ ||
                                reg_addr == irq_pkg::H_CLEAR_REQ)) begin
          next_bus_addr = (reg_addr == irq_pkg::H_PASS_READ) ?
                          pass_addr : reg_wdata;
          if (next_bus_addr == irq_pkg::VECTOR_ADDR) begin
            // a software read there would swallow a request
            set_st[irq_pkg::ST_REFUSED] = 1'b1;
            next_bus_addr = bus_addr;
          end else begin
            next_bus_rd = 1'b1;
            next_state  = (reg_addr == irq_pkg::H_PASS_READ) ?
                          irq_pkg::ST_PASS_RD : irq_pkg::ST_CLR_RD;
          end
        end else if (accept) begin
          next_bus_addr = irq_pkg::VECTOR_ADDR;
          next_bus_rd   = 1'b1;
          next_state    = irq_pkg::ST_ACK;
        end
      end
      irq_pkg::ST_ACK: begin
        if (rd_valid) begin
          next_vector              = link.rdata;
          next_i_flag              = 1'b0;
          set_st[irq_pkg::ST_TAKEN] = 1'b1;
          next_state               = irq_pkg::ST_IDLE;
        end
      end
      irq_pkg::ST_PASS_RD: begin
        if (rd_valid) begin
          next_pass_data = link.rdata;
          next_state     = irq_pkg::ST_IDLE;
        end
      end
      irq_pkg::ST_CLR_RD: begin
        // acceptance is held off for the whole read-and-write
        if (rd_valid) begin
          next_bus_wdata = link.rdata & irq_pkg::REQ_CLEAR_MASK;
          next_bus_wr    = 1'b1;
          next_state     = irq_pkg::ST_CLR_WR;
        end
      end
      irq_pkg::ST_CLR_WR: begin
        next_bus_addr = irq_pkg::DUMMY_ADDR;
        next_bus_rd   = 1'b1;
        next_state    = irq_pkg::ST_DUMMY;
      end
      irq_pkg::ST_DUMMY: begin
        if (rd_valid) begin
          set_st[irq_pkg::ST_CLEARED] = 1'b1;
          next_en_wait = wait_len(hold_mode);
          next_state   = irq_pkg::ST_IDLE;
        end
      end
      default: next_state = irq_pkg::ST_IDLE;
    endcase

    // ---------------------------------------------- status, reads
    next_status = (status & ~clr_st) | set_st;
    next_irq    = |(next_status & next_mask);
    if (reg_rd) begin
      case (reg_addr)
        irq_pkg::H_CTRL:
          next_reg_rdata = {9'h000, ipl, 2'h0, hold_mode, i_flag};
        irq_pkg::H_STATUS:    next_reg_rdata = {13'h0000, status};
        irq_pkg::H_MASK:      next_reg_rdata = {13'h0000, mask};
        irq_pkg::H_VECTOR:    next_reg_rdata = {8'h00, vector};
        irq_pkg::H_PASS_ADDR: next_reg_rdata = pass_addr;
        irq_pkg::H_PASS_DATA: next_reg_rdata = {8'h00, pass_data};
        irq_pkg::H_SP_STATE:
          next_reg_rdata = {12'h000, state != irq_pkg::ST_IDLE,
                            en_wait == 3'h0, sp_loaded, enabled};
        default:              next_reg_rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state     <= irq_pkg::ST_IDLE;
      i_flag    <= 1'b0;
      hold_mode <= 1'b0;
      ipl       <= 3'h0;
      en_wait   <= 3'h0;
      sp_loaded <= 1'b0;
      status    <= irq_pkg::STATUS_RESET;
      mask      <= 3'h0;
      vector    <= 8'h00;
      pass_addr <= 16'h0000;
      pass_data <= 8'h00;
      bus_addr  <= 16'h0000;
      bus_wdata <= 8'h00;
      bus_wr    <= 1'b0;
      bus_rd    <= 1'b0;
      rd_valid  <= 1'b0;
      reg_rdata <= 16'h0000;
      irq       <= 1'b0;
    end else begin
      state     <= next_state;
      i_flag    <= next_i_flag;
      hold_mode <= next_hold_mode;
      ipl       <= next_ipl;
      en_wait   <= next_en_wait;
      sp_loaded <= next_sp_loaded;
      status    <= next_status;
      mask      <= next_mask;
      vector    <= next_vector;
      pass_addr <= next_pass_addr;
      pass_data <= next_pass_data;
      bus_addr  <= next_bus_addr;
      bus_wdata <= next_bus_wdata;
      bus_wr    <= next_bus_wr;
      bus_rd    <= next_bus_rd;
      rd_valid  <= bus_rd;
      reg_rdata <= next_reg_rdata;
      irq       <= next_irq;
    end
  end

  assign link.addr  = bus_addr;
  assign link.wdata = bus_wdata;
  assign link.wr    = bus_wr;
  assign link.rd    = bus_rd;

endmodule // cpu_irq_seq

// >>> verif/irq_link_assertions.sv
// concurrent checks on the link between cpu sequencer and controller
`timescale 1ns/1ns
module irq_link_assertions (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // link signals
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        irq_req,
  input wire logic [2:0]  irq_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ==========================================================
  // read data and vector fetch
  property p_rdata_quiet;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read answer");
  property p_vec_level;
    rd && addr == irq_pkg::VECTOR_ADDR && irq_req
      |=> rdata[7:5] >= $past(irq_level) && rdata[7:5] != 3'h0;
  endproperty
  a_vec_level: assert property (p_vec_level)
    else $error("vector level below pending level");
  property p_req_level;
    irq_req |-> irq_level != 3'h0;
  endproperty
  a_req_level: assert property (p_req_level)
    else $error("request flagged with level zero");
  property p_vec_once;
    rd && addr == irq_pkg::VECTOR_ADDR
      |=> (!(rd && addr == irq_pkg::VECTOR_ADDR)) [*4];
  endproperty
  a_vec_once: assert property (p_vec_once)
    else $error("vector fetched again before enable");
  property p_vec_cause;
    rd && addr == irq_pkg::VECTOR_ADDR |-> $past(irq_req);
  endproperty
  a_vec_cause: assert property (p_vec_cause)
    else $error("vector read without pending request");

  // ==========================================================
  // request clear sequence and enable delay
  sequence s_clear_wr;
    wr && $past(rd, 2) && $past(addr, 2) == addr;
  endsequence
  property p_clear_mask;
    s_clear_wr |-> wdata == ($past(rdata) & irq_pkg::REQ_CLEAR_MASK);
  endproperty
  a_clear_mask: assert property (p_clear_mask)
    else $error("clear write does not drop only the request bit");
  property p_clear_dummy;
    s_clear_wr |=> rd && addr == irq_pkg::DUMMY_ADDR;
  endproperty
  a_clear_dummy: assert property (p_clear_dummy)
    else $error("no dummy read after clear write");
  property p_write_hold;
    wr |=> !(rd && addr == irq_pkg::VECTOR_ADDR);
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("vector fetch right after control write");

  c_vector: cover property (rd && addr == irq_pkg::VECTOR_ADDR);
  c_clear: cover property (s_clear_wr);
  c_irq: cover property ($rose(irq_req));
endmodule // irq_link_assertions

// >>> verif/test_interrupt_request_control.sv
// self-checking bench for both ends of the interrupt link
`timescale 1ns/1ns
module test_interrupt_request_control;
  logic        clk_sys;
  logic        reset;
  logic [3:0]  src_a, src_b, ev;
  logic [0:0]  pin_a, pin_b;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, sp_a, sp_b, v;
  logic        reg_wr, reg_rd, irq;
  logic [7:0]  mctl [4];
  logic [7:0]  ex;
  int          miscompares, num_checks, seed, k;

  irq_link_if i_irq_link_if ();
  irq_link_if i_irq_link_if_b ();
  irq_request_ctl #(.NUM_SRC(4), .NUM_EXT(1)) i_irq_request_ctl (
    .clk_sys(clk_sys), .reset(reset), .link(i_irq_link_if.dev),
    .src_event(src_a), .ext_pin(pin_a), .stack_ptr(sp_a));
  // second controller driven straight from the bench
  irq_request_ctl #(.NUM_SRC(4), .NUM_EXT(1)) i_irq_request_ctl_b (
    .clk_sys(clk_sys), .reset(reset), .link(i_irq_link_if_b.dev),
    .src_event(src_b), .ext_pin(pin_b), .stack_ptr(sp_b));
  cpu_irq_seq i_cpu_irq_seq (
    .clk_sys(clk_sys), .reset(reset), .link(i_irq_link_if.cpu),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  irq_link_assertions i_irq_link_assertions (
    .clk_sys(clk_sys), .reset(reset), .addr(i_irq_link_if.addr),
    .wdata(i_irq_link_if.wdata), .wr(i_irq_link_if.wr),
    .rd(i_irq_link_if.rd), .rdata(i_irq_link_if.rdata),
    .irq_req(i_irq_link_if.irq_req), .irq_level(i_irq_link_if.irq_level));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // checking, expectation and bus tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // top enabled request: highest level, ties to the lowest index
  function automatic logic [7:0] vec(input logic [7:0] c [4]);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 3; i >= 0; i--)
      if (c[i][3] && c[i][2:0] != 3'h0 && c[i][2:0] >= r[7:5])
        r = {c[i][2:0], 5'(i)};
    return r;
  endfunction

  // software port access, events to pair a ride on the same cycle
  task automatic sw(input logic [3:0] a, input logic [15:0] d,
                    input bit rd, input logic [3:0] e);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= !rd;
    reg_rd    <= rd;
    src_a     <= e;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    src_a     <= 4'h0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1 v = reg_rdata;
    repeat (2) @(posedge clk_sys);
  endtask

  // direct device access on the second link
  task automatic dv(input logic [15:0] a, input logic [7:0] d,
                    input bit rd, input logic [3:0] e);
    @(posedge clk_sys);
    i_irq_link_if_b.addr  <= a;
    i_irq_link_if_b.wdata <= d;
    i_irq_link_if_b.wr    <= !rd;
    i_irq_link_if_b.rd    <= rd;
    src_b                 <= e;
    @(posedge clk_sys);
    i_irq_link_if_b.wr    <= 1'b0;
    i_irq_link_if_b.rd    <= 1'b0;
    i_irq_link_if_b.addr  <= ~a;
    i_irq_link_if_b.wdata <= ~d;
    src_b                 <= 4'h0;
    #1 v = {8'h00, i_irq_link_if_b.rdata};
  endtask

  task automatic stop_test;
    $display("Checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'he053add0;
    miscompares = 0;
    num_checks = 0;
    reset = 1'b1;
    src_a = 4'h0;
    src_b = 4'h0;
    pin_a = 1'b1;
    pin_b = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    i_irq_link_if_b.addr = 16'hffff;
    i_irq_link_if_b.wdata = 8'h00;
    i_irq_link_if_b.wr = 1'b0;
    i_irq_link_if_b.rd = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    check(sp_b, irq_pkg::SP_RESET);
    dv(irq_pkg::SP_LO_ADDR, 8'h00, 1'b1, 4'h0);
    check(v, 16'h0000);
    dv(16'h0100, 8'h5a, 1'b0, 4'h0);
    dv(16'h0100, 8'h00, 1'b1, 4'h0);
    check(v, 16'h0000);
    // polarity flip with the pin high raises the external request
    dv(16'h0058, 8'h11, 1'b0, 4'h0);
    dv(16'h0058, 8'h00, 1'b1, 4'h0);
    check(v, 16'h0019);
    dv(16'h0058, 8'h10, 1'b0, 4'h0);
    dv(16'h0058, 8'h00, 1'b1, 4'h0);
    check(v, 16'h0010);
    mctl[3] = 8'h10;
    // event landing on a control rewrite keeps its request
    dv(irq_pkg::CTRL_BASE_ADDR, 8'h05, 1'b0, 4'h1);
    dv(irq_pkg::CTRL_BASE_ADDR, 8'h00, 1'b1, 4'h0);
    check(v, 16'h000d);
    for (k = 0; k < 24; k++) begin
      for (int i = 0; i < 3; i++) begin
        mctl[i] = {5'h00, 3'($random(seed))};
        dv(irq_pkg::CTRL_BASE_ADDR + 16'(i), mctl[i], 1'b0, 4'h0);
      end
      ev = 4'($random(seed)) & 4'h7;
      dv(16'h0100, 8'h00, 1'b1, ev);
      for (int i = 0; i < 3; i++)
        if (ev[i]) mctl[i][3] = 1'b1;
      ex = vec(mctl);
      dv(irq_pkg::VECTOR_ADDR, 8'h00, 1'b1, 4'h0);
      check(v, {8'h00, ex});
      if (ex != 8'h00) mctl[ex[1:0]][3] = 1'b0;
      dv(irq_pkg::CTRL_BASE_ADDR + 16'(ex[1:0]), 8'h00, 1'b1, 4'h0);
      check(v, {8'h00, mctl[ex[1:0]]});
      check(16'(i_irq_link_if_b.irq_level), 16'(vec(mctl) >> 5));
      check(16'(i_irq_link_if_b.irq_req), 16'(vec(mctl) != 8'h00));
    end
    // rising edge on the external pin raises its request
    @(posedge clk_sys);
    pin_b <= 1'b0;
    @(posedge clk_sys);
    pin_b <= 1'b1;
    dv(16'h0058, 8'h00, 1'b1, 4'h0);
    check(v, 16'h0018);
    // acceptance waits for a loaded stack pointer
    check(sp_a, irq_pkg::SP_RESET);
    sw(irq_pkg::H_MASK, 16'h0000, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_ADDR, 16'h0055, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_DATA, 16'h0003, 1'b0, 4'h0);
    sw(irq_pkg::H_CTRL, 16'h0001, 1'b0, 4'h0);
    sw(irq_pkg::H_STATUS, 16'h0000, 1'b1, 4'h1);
    repeat (10) @(posedge clk_sys);
    sw(irq_pkg::H_STATUS, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0000);
    sw(irq_pkg::H_PASS_ADDR, irq_pkg::SP_HI_ADDR, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_DATA, 16'h0010, 1'b0, 4'h0);
    check(sp_a, 16'h1000);
    repeat (10) @(posedge clk_sys);
    sw(irq_pkg::H_STATUS, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0001);
    check({15'h0000, irq}, 16'h0000);
    sw(irq_pkg::H_VECTOR, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0060);
    sw(irq_pkg::H_MASK, 16'h0001, 1'b0, 4'h0);
    check({15'h0000, irq}, 16'h0001);
    sw(irq_pkg::H_STATUS, 16'h0001, 1'b0, 4'h0);
    check({15'h0000, irq}, 16'h0000);
    sw(irq_pkg::H_PASS_ADDR, 16'h0055, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_READ, 16'h0000, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_DATA, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0003);
    // clear sequence drops only the request bit
    sw(irq_pkg::H_CTRL, 16'h0000, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_ADDR, 16'h0056, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_DATA, 16'h0002, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_READ, 16'h0000, 1'b0, 4'h2);
    sw(irq_pkg::H_PASS_DATA, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h000a);
    sw(irq_pkg::H_STATUS, 16'h0007, 1'b0, 4'h0);
    sw(irq_pkg::H_CLEAR_REQ, 16'h0056, 1'b0, 4'h0);
    repeat (6) @(posedge clk_sys);
    sw(irq_pkg::H_STATUS, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0002);
    sw(irq_pkg::H_PASS_READ, 16'h0000, 1'b0, 4'h0);
    sw(irq_pkg::H_PASS_DATA, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0002);
    // software access to the vector address is refused
    sw(irq_pkg::H_STATUS, 16'h0007, 1'b0, 4'h0);
    sw(irq_pkg::H_CLEAR_REQ, 16'h0000, 1'b0, 4'h0);
    sw(irq_pkg::H_STATUS, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0004);
    sw(4'hf, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0000);
    // hold mode stretches the enable delay to four slots
    sw(irq_pkg::H_CTRL, 16'h0003, 1'b0, 4'h0);
    sw(irq_pkg::H_SP_STATE, 16'h0000, 1'b1, 4'h0);
    check(v, 16'h0002);
    stop_test();
  end
endmodule // test_interrupt_request_control
